// File: pkg/nand_strobe_defines.vh
// Constants for the NAND flash strobe sequencer: timing figures, field widths and reset values.
// Assumes inclusion by bare name from the design files; definitions only.
// Contract
// - Asymmetric mode spends two flash clock periods per read or write strobe, symmetric mode one.
// - The flash clock is made from the slow memory clock by one programmable integer divider.
// - With the ready/busy source mode at 1, ready/busy comes from pin 0 and the capture delay line must be set.
// - The capture delay is four equal units, each 1.25 ns up to one memory clock period, defaulting to a quarter period.
// - The memory slow clock period used for delay and hold figures defaults to 7.5 ns (133 MHz).
// - With more than zero attached devices, chip-enable setup shrinks to 1.5 flash periods in the symmetric data phase only.
`ifndef NAND_STROBE_DEFINES_VH
`define NAND_STROBE_DEFINES_VH
`define CLK_PERIOD_PS 25000
`define ACLK_PERIOD_PS 7500
`define DL_UNIT_MIN_PS 1250
`define DL_UNIT_DEFAULT_PS (`ACLK_PERIOD_PS / 4)
`define DL_UNITS 4
`define DL_TOTAL_DEFAULT_PS 18'h1d4c
`define DIV_W 4
`define DIV_RESET 4'h3
`define DL_W 16
`define CE_SETUP_FULL_TICKS 3'h6
`define CE_SETUP_HALF_TICKS 3'h3
`define MODE_ASYM 1'b0
`define MODE_SYM 1'b1
`endif

// File: hdl/strobe_fifo.v
// Synchronous FIFO with valid/ready on both sides, flip-flop storage.
// Assumes one clock and a synchronised active-low reset.
`timescale 1ns/1ps
module strobe_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire rst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // strobe_fifo

// File: hdl/nand_strobe_seq.v
// NAND flash strobe sequencer: divided flash clock, read/write strobes, chip-enable setup,
// ready/busy source choice, delay-line setting and read data buffering.
// Assumes a 40 MHz REF_CLK standing in for the slow memory clock and asynchronous pin inputs.
`timescale 1ns/1ps
`include "nand_strobe_defines.vh"
module nand_strobe_seq #(
	parameter DATA_W = 16,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire REF_CLK,
	input wire RESET_N,
	input wire [`DIV_W-1:0] CLK_DIVIDER,
	input wire STROBE_MODE,
	input wire READY_BUSY_SOURCE_MODE,
	input wire [1:0] ATTACHED_DEVICE_COUNT,
	input wire [`DL_W-1:0] DELAY_UNIT_PS,
	input wire REQ_VALID,
	input wire REQ_WRITE,
	input wire [DATA_W-1:0] REQ_WDATA,
	output reg REQ_READY,
	output wire RDATA_VALID,
	input wire RDATA_READY,
	output wire [DATA_W-1:0] RDATA,
	input wire READY_BUSY_PIN0,
	input wire READY_BUSY_PIN1,
	input wire [DATA_W-1:0] FLASH_DATA_IN,
	output reg [DATA_W-1:0] FLASH_DATA_OUT,
	output reg FLASH_DATA_OE,
	output reg CHIP_ENABLE_N,
	output reg READ_STROBE_N,
	output reg WRITE_STROBE_N,
	output reg FLASH_CLK,
	output reg FLASH_READY,
	output reg [`DL_W+1:0] CAPTURE_DELAY_PS
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_SETUP = 3'h1;
	localparam [2:0] ST_LOW = 3'h2;
	localparam [2:0] ST_HIGH = 3'h3;
	localparam [2:0] ST_PUSH = 3'h4;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and input synchronisers.
	reg [1:0] rst_sync;
	wire rst_n;
	assign rst_n = rst_sync[1];
	always @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	reg [1:0] rb0_sync;
	reg [1:0] rb1_sync;
	reg [DATA_W-1:0] din_s1;
	reg [DATA_W-1:0] din_s2;
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rb0_sync <= 2'h0;
			rb1_sync <= 2'h0;
			din_s1 <= {DATA_W{1'b0}};
			din_s2 <= {DATA_W{1'b0}};
		end
		else
		begin
			rb0_sync <= {rb0_sync[0], READY_BUSY_PIN0};
			rb1_sync <= {rb1_sync[0], READY_BUSY_PIN1};
			din_s1 <= FLASH_DATA_IN;
			din_s2 <= din_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flash clock divider; a tick marks each half flash period.
	reg [`DIV_W-1:0] div_cnt;
	wire tick;
	// A divider value of zero gives a half period of one REF_CLK cycle, so the flash clock never stops.
	assign tick = (div_cnt == {`DIV_W{1'b0}});
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt <= {`DIV_W{1'b0}};
			FLASH_CLK <= 1'b0;
		end
		else if (tick)
		begin
			div_cnt <= CLK_DIVIDER;
			FLASH_CLK <= ~FLASH_CLK;
		end
		else
			div_cnt <= div_cnt - 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Ready/busy source and delay-line setting.
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			FLASH_READY <= 1'b0;
			CAPTURE_DELAY_PS <= {(`DL_W+2){1'b0}};
		end
		else
		begin
			FLASH_READY <= READY_BUSY_SOURCE_MODE ? rb0_sync[1] : (rb0_sync[1] & rb1_sync[1]);
			// Units below the minimum or above one memory period fall back to a quarter memory period each.
			if (DELAY_UNIT_PS < `DL_UNIT_MIN_PS || DELAY_UNIT_PS > `ACLK_PERIOD_PS)
				CAPTURE_DELAY_PS <= `DL_TOTAL_DEFAULT_PS;
			else
				CAPTURE_DELAY_PS <= {2'h0, DELAY_UNIT_PS} << 2;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strobe sequencer, moving on half-period ticks.
	reg [2:0] state;
	reg [2:0] half_cnt;
	reg mode;
	reg is_write;
	reg [DATA_W-1:0] cap_data;
	reg cap_valid;
	reg [1:0] cap_pend;
	wire fifo_ready;
	wire push_now;
	wire [2:0] setup_halves;
	wire [2:0] low_halves;
	wire [2:0] high_halves;
	// Interleaved devices shorten chip-enable setup, only in the symmetric data phase.
	assign setup_halves = (mode == `MODE_SYM && ATTACHED_DEVICE_COUNT != 2'h0) ?
		`CE_SETUP_HALF_TICKS : `CE_SETUP_FULL_TICKS;
	// Asymmetric: low 3 halves + high 1 half = 2T; symmetric: 1 + 1 = 1T.
	assign low_halves = (mode == `MODE_ASYM) ? 3'h3 : 3'h1;
	assign high_halves = 3'h1;
	assign push_now = (state == ST_PUSH) && (cap_pend == 2'h0);

	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			half_cnt <= 3'h0;
			mode <= `MODE_ASYM;
			is_write <= 1'b0;
			cap_data <= {DATA_W{1'b0}};
			cap_valid <= 1'b0;
			cap_pend <= 2'h0;
			REQ_READY <= 1'b0;
			FLASH_DATA_OUT <= {DATA_W{1'b0}};
			FLASH_DATA_OE <= 1'b0;
			CHIP_ENABLE_N <= 1'b1;
			READ_STROBE_N <= 1'b1;
			WRITE_STROBE_N <= 1'b1;
		end
		else
		begin
			REQ_READY <= 1'b0;
			// The data synchroniser lags two cycles, so the word that stood on the bus as the
			// strobe rose is taken two cycles later.
			cap_pend <= {cap_pend[0], 1'b0};
			if (cap_pend[1])
				cap_data <= din_s2;
			case (state)
			ST_IDLE:
			begin
				if (REQ_VALID && !REQ_READY && FLASH_READY && fifo_ready)
				begin
					mode <= STROBE_MODE;
					is_write <= REQ_WRITE;
					FLASH_DATA_OUT <= REQ_WDATA;
					FLASH_DATA_OE <= REQ_WRITE;
					CHIP_ENABLE_N <= 1'b0;
					half_cnt <= 3'h0;
					state <= ST_SETUP;
				end
			end
			ST_SETUP:
			begin
				if (tick)
				begin
					if (half_cnt + 3'h1 >= setup_halves)
					begin
						half_cnt <= 3'h0;
						READ_STROBE_N <= is_write;
						WRITE_STROBE_N <= ~is_write;
						state <= ST_LOW;
					end
					else
						half_cnt <= half_cnt + 3'h1;
				end
			end
			ST_LOW:
			begin
				if (tick)
				begin
					if (half_cnt + 3'h1 >= low_halves)
					begin
						half_cnt <= 3'h0;
						cap_pend <= {cap_pend[0], ~is_write};
						READ_STROBE_N <= 1'b1;
						WRITE_STROBE_N <= 1'b1;
						state <= ST_HIGH;
					end
					else
						half_cnt <= half_cnt + 3'h1;
				end
			end
			ST_HIGH:
			begin
				if (tick)
				begin
					if (half_cnt + 3'h1 >= high_halves)
					begin
						half_cnt <= 3'h0;
						CHIP_ENABLE_N <= 1'b1;
						FLASH_DATA_OE <= 1'b0;
						cap_valid <= ~is_write;
						state <= ST_PUSH;
					end
					else
						half_cnt <= half_cnt + 3'h1;
				end
			end
			ST_PUSH:
			begin
				// Space was checked before the access began, so the push cannot stall.
				if (push_now && (!cap_valid || fifo_ready))
				begin
					cap_valid <= 1'b0;
					REQ_READY <= 1'b1;
					state <= ST_IDLE;
				end
			end
			default:
				state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data buffer; a full buffer holds off new requests.
	// The output register adds one place, so seventeen words fit before requests wait.
	reg rdata_held;
	reg [DATA_W-1:0] rdata_word;
	wire fifo_out_valid;
	wire [DATA_W-1:0] fifo_out_data;
	wire fifo_pop;
	assign fifo_pop = fifo_out_valid && (!rdata_held || RDATA_READY);
	assign RDATA_VALID = rdata_held;
	assign RDATA = rdata_word;
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_held <= 1'b0;
			rdata_word <= {DATA_W{1'b0}};
		end
		else if (fifo_pop)
		begin
			rdata_held <= 1'b1;
			rdata_word <= fifo_out_data;
		end
		else if (RDATA_READY)
			rdata_held <= 1'b0;
	end

	strobe_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_rdata_fifo (
		.clk(REF_CLK),
		.rst_n(rst_n),
		.in_valid(cap_valid && push_now),
		.in_ready(fifo_ready),
		.in_data(cap_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);
endmodule // nand_strobe_seq

// File: tb/nand_strobe_seq_properties.sv
// Port checker for the strobe sequencer.
// Assumes CLK_DIVIDER stays 4'h1 while strobes run.
`timescale 1ns/1ps
module nand_strobe_seq_properties (
	input wire REF_CLK,
	input wire RESET_N,
	input wire [3:0] CLK_DIVIDER,
	input wire STROBE_MODE,
	input wire READY_BUSY_SOURCE_MODE,
	input wire [15:0] DELAY_UNIT_PS,
	input wire REQ_READY,
	input wire RDATA_VALID,
	input wire RDATA_READY,
	input wire [15:0] RDATA,
	input wire READY_BUSY_PIN0,
	input wire CHIP_ENABLE_N,
	input wire FLASH_DATA_OE,
	input wire READ_STROBE_N,
	input wire WRITE_STROBE_N,
	input wire FLASH_READY,
	input wire [17:0] CAPTURE_DELAY_PS
);
wire strb = READ_STROBE_N & WRITE_STROBE_N;
reg [2:0] up;
wire run = (up == 3'h7);
always @(posedge REF_CLK or negedge RESET_N)
	if (!RESET_N)
		up <= 3'h0;
	else if (!run)
		up <= up + 3'h1;
default clocking @(posedge REF_CLK); endclocking
default disable iff (!RESET_N);
sequence s_asym_low; !strb [*6] ##1 strb; endsequence
sequence s_sym_low; !strb [*2] ##1 strb; endsequence
property p_asym; $fell(strb) && !STROBE_MODE && CLK_DIVIDER == 4'h1 |-> s_asym_low; endproperty
property p_sym; $fell(strb) && STROBE_MODE && CLK_DIVIDER == 4'h1 |-> s_sym_low; endproperty
property p_pulse; REQ_READY |=> !REQ_READY; endproperty
property p_done_ce; REQ_READY |-> CHIP_ENABLE_N; endproperty
property p_strb_ce; !strb |-> !CHIP_ENABLE_N; endproperty
property p_ce_hold; $rose(strb) |-> !CHIP_ENABLE_N; endproperty
property p_delay; (run && $stable(DELAY_UNIT_PS)) [*3] |-> CAPTURE_DELAY_PS ==
	((DELAY_UNIT_PS >= 16'h04e2 && DELAY_UNIT_PS <= 16'h1d4c) ? {DELAY_UNIT_PS, 2'h0} : 18'h1d4c);
endproperty
property p_rdy; (run && READY_BUSY_SOURCE_MODE && READY_BUSY_PIN0) [*4] |-> FLASH_READY; endproperty
property p_bsy; (run && READY_BUSY_SOURCE_MODE && !READY_BUSY_PIN0) [*4] |-> !FLASH_READY; endproperty
property p_hold; RDATA_VALID && !RDATA_READY |=> RDATA_VALID && $stable(RDATA); endproperty
property p_oe; !strb |-> FLASH_DATA_OE == !WRITE_STROBE_N; endproperty
a_asym:
	assert property (p_asym) else $error("asymmetric strobe length wrong");
a_sym:
	assert property (p_sym) else $error("symmetric strobe length wrong");
a_pulse:
	assert property (p_pulse) else $error("done pulse too long");
a_done_ce:
	assert property (p_done_ce) else $error("done while chip enabled");
a_strb_ce:
	assert property (p_strb_ce) else $error("strobe without chip enable");
a_ce_hold:
	assert property (p_ce_hold) else $error("chip enable dropped early");
a_delay:
	assert property (p_delay) else $error("capture delay wrong");
a_rdy:
	assert property (p_rdy) else $error("ready not seen");
a_bsy:
	assert property (p_bsy) else $error("busy not seen");
a_hold:
	assert property (p_hold) else $error("read word unstable");
a_oe:
	assert property (p_oe) else $error("data drive does not follow the strobe");
endmodule // nand_strobe_seq_properties

// File: tb/flash_model.sv
// One-word flash part on the strobe pins; busy for a while after a write.
// Assumes synchronous sampling of the strobes by the bench clock.
`timescale 1ns/1ps
module flash_model (
	input wire clk,
	input wire ce_n,
	input wire re_n,
	input wire we_n,
	input wire [15:0] din,
	output reg [15:0] dout,
	output wire rb
);
reg [15:0] word = 16'h0000;
reg [3:0] busy = 4'h0;
reg [1:0] hold = 2'h0;
assign rb = (busy == 4'h0);
always @(posedge clk)
begin
	if (!ce_n && !we_n)
		word <= din;
	if (!ce_n && !we_n)
		busy <= 4'h8;
	else if (!rb)
		busy <= busy - 4'h1;
	if (!ce_n && !re_n)
	begin
		dout <= word;
		hold <= 2'h3; // The word outlasts the strobe, as a bus keeper holds it.
	end
	else if (hold != 2'h0)
		hold <= hold - 2'h1;
	else
		dout <= ~dout; // A released bus must not look valid.
end
endmodule // flash_model

// File: tb/test_nand_strobe_seq.sv
// Bench for the strobe sequencer against the flash model.
// Assumes the design and the checker are compiled first.
`timescale 1ns/1ps
module test_nand_strobe_seq;
reg REF_CLK = 1'b0, RESET_N = 1'b0, STROBE_MODE = 1'b0, REQ_VALID = 1'b0, REQ_WRITE = 1'b0;
reg READY_BUSY_SOURCE_MODE = 1'b1, RDATA_READY = 1'b0, READY_BUSY_PIN1 = 1'b1, ok;
reg [1:0] ATTACHED_DEVICE_COUNT = 2'h0;
reg [3:0] CLK_DIVIDER = 4'h1; // Start-up divider, in place of the boot clock setting.
reg [15:0] DELAY_UNIT_PS = 16'h0753, REQ_WDATA = 16'h0000;
wire [15:0] RDATA, FLASH_DATA_IN, FLASH_DATA_OUT;
wire [17:0] CAPTURE_DELAY_PS;
wire REQ_READY, RDATA_VALID, PIN0, FLASH_DATA_OE, CHIP_ENABLE_N, READ_STROBE_N, WRITE_STROBE_N;
wire FLASH_CLK, FLASH_READY;
integer error_cnt = 0, checked = 0, i;
reg [19:0] rows [0:3] = '{20'h1a5c3, 20'h0a5c3, 20'h93c96, 20'hc3c96};
reg [33:0] dl [0:3] = '{{16'h03e8, 18'h1d4c}, {16'h04e2, 18'h1388}, {16'h1d4c, 18'h07530},
	{16'h1d4d, 18'h1d4c}};
always #12.5 REF_CLK = ~REF_CLK;
nand_strobe_seq DUT (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .CLK_DIVIDER(CLK_DIVIDER),
	.STROBE_MODE(STROBE_MODE), .READY_BUSY_SOURCE_MODE(READY_BUSY_SOURCE_MODE),
	.ATTACHED_DEVICE_COUNT(ATTACHED_DEVICE_COUNT), .DELAY_UNIT_PS(DELAY_UNIT_PS),
	.REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY),
	.RDATA_VALID(RDATA_VALID), .RDATA_READY(RDATA_READY), .RDATA(RDATA), .READY_BUSY_PIN0(PIN0),
	.READY_BUSY_PIN1(READY_BUSY_PIN1), .FLASH_DATA_IN(FLASH_DATA_IN),
	.FLASH_DATA_OUT(FLASH_DATA_OUT), .FLASH_DATA_OE(FLASH_DATA_OE),
	.CHIP_ENABLE_N(CHIP_ENABLE_N), .READ_STROBE_N(READ_STROBE_N),
	.WRITE_STROBE_N(WRITE_STROBE_N), .FLASH_CLK(FLASH_CLK), .FLASH_READY(FLASH_READY),
	.CAPTURE_DELAY_PS(CAPTURE_DELAY_PS));
flash_model u_flash (.clk(REF_CLK), .ce_n(CHIP_ENABLE_N), .re_n(READ_STROBE_N),
	.we_n(WRITE_STROBE_N), .din(FLASH_DATA_OUT), .dout(FLASH_DATA_IN), .rb(PIN0));
task chk(input string what, input logic [17:0] exp, got);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	end
endtask
task close_out;
	begin
		if (error_cnt == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
endtask
task access(input [19:0] r);
	integer n;
	begin
		@(posedge REF_CLK);
		{STROBE_MODE, ATTACHED_DEVICE_COUNT, REQ_WRITE, REQ_WDATA} <= r;
		REQ_VALID <= 1'b1;
		ok = 1'b0;
		for (n = 0; n < 300 && !ok; n = n + 1)
		begin
			@(negedge REF_CLK);
			ok = (REQ_READY === 1'b1);
		end
		@(posedge REF_CLK);
		REQ_VALID <= 1'b0;
	end
endtask
task pop(input [15:0] exp);
	begin
		@(negedge REF_CLK);
		chk("read word", {2'h1, exp}, {1'b0, RDATA_VALID, RDATA});
		@(posedge REF_CLK) RDATA_READY <= 1'b1;
		@(posedge REF_CLK) RDATA_READY <= 1'b0;
	end
endtask
task rst_chk;
	begin
		@(posedge REF_CLK);
		RESET_N <= 1'b0;
		repeat (4) @(posedge REF_CLK);
		chk("idle pins", 18'h38, {12'h0, CHIP_ENABLE_N, READ_STROBE_N, WRITE_STROBE_N,
			FLASH_DATA_OE, REQ_READY, FLASH_CLK});
		chk("reset delay", 18'h0, CAPTURE_DELAY_PS);
		RESET_N <= 1'b1;
		repeat (10) @(posedge REF_CLK);
	end
endtask
initial
begin
	repeat (20000) @(posedge REF_CLK);
	error_cnt = error_cnt + 1;
	close_out;
end
initial
begin
	rst_chk;
	for (i = 0; i < 4; i = i + 1)
	begin
		access(rows[i]);
		chk("taken", 18'h1, {17'h0, ok});
		if (!rows[i][16])
			pop(rows[i][15:0]);
	end
	READY_BUSY_PIN1 <= 1'b0;
	READY_BUSY_SOURCE_MODE <= 1'b0;
	repeat (8) @(negedge REF_CLK);
	chk("ready both", 18'h0, {17'h0, FLASH_READY});
	access(rows[1]);
	chk("refused", 18'h0, {17'h0, ok});
	READY_BUSY_SOURCE_MODE <= 1'b1;
	repeat (8) @(negedge REF_CLK);
	chk("ready pin0", 18'h1, {17'h0, FLASH_READY});
	// Sixteen words in the buffer and one in the output register; the next read must wait.
	for (i = 0; i < 18; i = i + 1)
	begin
		access(rows[1]);
		chk("fill", {17'h0, i < 17}, {17'h0, ok});
	end
	for (i = 0; i < 17; i = i + 1)
		pop(rows[2][15:0]);
	@(negedge REF_CLK);
	chk("empty", 18'h0, {17'h0, RDATA_VALID});
	for (i = 0; i < 4; i = i + 1)
	begin
		@(posedge REF_CLK) DELAY_UNIT_PS <= dl[i][33:18];
		repeat (4) @(negedge REF_CLK);
		chk("delay", dl[i][17:0], CAPTURE_DELAY_PS);
	end
	@(posedge REF_CLK) CLK_DIVIDER <= 4'h2;
	repeat (8) @(negedge REF_CLK);
	ok = FLASH_CLK;
	for (i = 0; i < 8 && FLASH_CLK === ok; i = i + 1)
		@(negedge REF_CLK);
	ok = FLASH_CLK;
	for (i = 0; i < 8 && FLASH_CLK === ok; i = i + 1)
		@(negedge REF_CLK);
	chk("flash clock half period", 18'h3, i[17:0]);
	rst_chk;
	close_out;
end
endmodule // test_nand_strobe_seq
bind nand_strobe_seq nand_strobe_seq_properties u_props (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
	.CLK_DIVIDER(CLK_DIVIDER), .STROBE_MODE(STROBE_MODE),
	.READY_BUSY_SOURCE_MODE(READY_BUSY_SOURCE_MODE), .DELAY_UNIT_PS(DELAY_UNIT_PS),
	.REQ_READY(REQ_READY), .RDATA_VALID(RDATA_VALID), .RDATA_READY(RDATA_READY),
	.RDATA(RDATA), .READY_BUSY_PIN0(READY_BUSY_PIN0), .CHIP_ENABLE_N(CHIP_ENABLE_N),
	.FLASH_DATA_OE(FLASH_DATA_OE), .READ_STROBE_N(READ_STROBE_N),
	.WRITE_STROBE_N(WRITE_STROBE_N), .FLASH_READY(FLASH_READY),
	.CAPTURE_DELAY_PS(CAPTURE_DELAY_PS));
